// File: verilog/mdsg_regs.svh
// register map, field positions and timing constants of the motor signal generator
`ifndef MDSG_REGS_SVH
`define MDSG_REGS_SVH

`define MDSG_A_CTRL       8'h00
`define MDSG_A_PWM0       8'h04
`define MDSG_A_PWM_STRIDE 8'h04
`define MDSG_A_TARGET     8'h14
`define MDSG_A_ACCEL      8'h18
`define MDSG_A_TBASE      8'h1c
`define MDSG_A_STATUS     8'h20

`define MDSG_B_ENABLE     0
`define MDSG_B_DRVRST     1
`define MDSG_B_DIR        2
`define MDSG_B_MODE_LO    3
`define MDSG_B_MODE_HI    4
`define MDSG_B_RUN        5
`define MDSG_B_PULSE      6

`define MDSG_S_RUNNING    16
`define MDSG_S_CRUISE     17
`define MDSG_S_STEP       18

`define MDSG_MODE_RSVD    2'h3
`define MDSG_DUTY_MAX     8'hff

`define MDSG_CLK_HZ       100000000
`define MDSG_CLK_PER_NS   10
`define MDSG_PWM_HZ       31250
`define MDSG_PWM_STEPS    255
`define MDSG_PWM_PRE      ((`MDSG_CLK_HZ + `MDSG_PWM_HZ * `MDSG_PWM_STEPS / 2) / (`MDSG_PWM_HZ * `MDSG_PWM_STEPS))
`define MDSG_STEP_HI_NS   1000
`define MDSG_STEP_HI      8'((`MDSG_STEP_HI_NS + `MDSG_CLK_PER_NS - 1) / `MDSG_CLK_PER_NS)
`define MDSG_MS_NS        1000000
`define MDSG_MS_CYC       (`MDSG_MS_NS / `MDSG_CLK_PER_NS)

`endif

// File: verilog/mdsg_pkg.sv
// types shared by the motor signal generator
package mdsg_pkg;
  typedef enum logic [3:0] {
    MDSG_IDLE  = 4'h1,
    MDSG_RAMP  = 4'h2,
    MDSG_CRUISE = 4'h4,
    MDSG_DECEL = 4'h8
  } mdsg_state_t;
endpackage

// File: verilog/mdsg_top.sv
// motor driver control signal generator: enable, reset, pwm inputs, step/dir, ramp
// How it works
// RULE1: enable output low enables driver, high disables it.
// RULE2: reset output held low normally; high then low resets driver.
// RULE3: bridge input constant high means 100 percent, constant low 0 percent.
// RULE4: one low-to-high step edge per motor step.
// RULE5: direction output high is forward, low is reverse.
// RULE6: step mode 00 full, 01 half, 10 wave; 11 never driven.
// RULE7: each pwm channel takes an 8-bit duty setting 0..255.
// RULE8: pwm period gives roughly 31.25 kHz.
// RULE9: duty equals setting over 255; 0 always low, 255 always high.
// RULE10: on start, rate grows by accel increment each ramp interval to target.
// RULE11: ramp interval equals time base setting in milliseconds.
// RULE12: at target, increments stop and stepping continues at target.
// RULE13: on stop, rate falls by increment each interval before halting.
// RULE14: acceleration and deceleration share increment and time base.
// RULE15: ramp clamps at target and at zero, never overshooting.
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "mdsg_regs.svh"
module mdsg_top
  import mdsg_pkg::*;
#(
  parameter int MS_CYCLES = `MDSG_MS_CYC
)
(
  input  wire logic        mclk,             // system clock, 100 MHz
  input  wire logic        rst_n,            // synchronous reset, active low
  input  wire logic [7:0]  addr,             // register byte address
  input  wire logic [31:0] wdata,            // write data
  input  wire logic        wr_en,            // write strobe
  input  wire logic        rd_en,            // read strobe
  output logic      [31:0] rdata,            // read data, cycle after rd_en
  output logic             drive_enable_low, // driver enable, active low
  output logic             drv_reset,        // driver reset line
  output logic      [3:0]  bridge_input_x,   // direct bridge pwm inputs
  output logic             step_out,         // step pulse
  output logic             dir_out,          // rotation sense
  output logic             step_mode_hi,     // step mode high bit
  output logic             step_mode_lo      // step mode low bit
);

  localparam logic [27:0] CLK_HZ = 28'(`MDSG_CLK_HZ);
  localparam logic [3:0]  PWM_PRE = 4'(`MDSG_PWM_PRE - 1);
  localparam logic [16:0] MS_LAST = 17'(MS_CYCLES - 1);

  // control and setting registers
  logic        en_low_reg, en_low_next;
  logic        drst_reg, drst_next;
  logic        dir_reg, dir_next;
  logic [1:0]  mode_reg, mode_next;
  logic        run_reg, run_next;
  logic        pulse_req;
  logic [7:0]  duty_reg [4];
  logic [7:0]  duty_next [4];
  logic [15:0] target_reg, target_next;
  logic [7:0]  inc_reg, inc_next;
  logic [7:0]  tb_reg, tb_next;
  logic [31:0] rdata_reg, rdata_next;

  // ramp, timing and step state
  mdsg_state_t state_reg, state_next;
  logic [15:0] rate_reg, rate_next;
  logic [16:0] ms_cnt_reg, ms_cnt_next;
  logic [7:0]  tb_cnt_reg, tb_cnt_next;
  logic [27:0] acc_reg, acc_next;
  logic [7:0]  step_cnt_reg, step_cnt_next;
  logic        step_reg, step_next;
  logic [3:0]  pre_reg, pre_next;
  logic [7:0]  pwm_cnt_reg, pwm_cnt_next;
  logic [3:0]  pwm_reg, pwm_next;

  logic        ms_tick, ramp_tick, step_event;
  logic [16:0] up_sum;
  logic [15:0] toward, down0;
  logic [28:0] acc_sum;

  // register writes and reads
  always_comb
  begin
    en_low_next = en_low_reg;
    drst_next   = drst_reg;
    dir_next    = dir_reg;
    mode_next   = mode_reg;
    run_next    = run_reg;
    pulse_req   = 1'b0;
    target_next = target_reg;
    inc_next    = inc_reg;
    tb_next     = tb_reg;
    for (int i = 0; i < 4; i++)
    begin
      duty_next[i] = duty_reg[i];
      if (wr_en && addr == `MDSG_A_PWM0 + 8'(i) * `MDSG_A_PWM_STRIDE)
        duty_next[i] = wdata[7:0];                         // [RULE7]
    end
    if (wr_en)
    begin
      case (addr)
        `MDSG_A_CTRL:
        begin
          en_low_next = ~wdata[`MDSG_B_ENABLE];            // [RULE1]
          drst_next   = wdata[`MDSG_B_DRVRST];             // [RULE2]
          dir_next    = wdata[`MDSG_B_DIR];                // [RULE5]
          // a reserved mode write is dropped so the pins never show it
          if (wdata[`MDSG_B_MODE_HI:`MDSG_B_MODE_LO] != `MDSG_MODE_RSVD)
            mode_next = wdata[`MDSG_B_MODE_HI:`MDSG_B_MODE_LO]; // [RULE6]
          run_next    = wdata[`MDSG_B_RUN];
          pulse_req   = wdata[`MDSG_B_PULSE];
        end
        `MDSG_A_TARGET: target_next = wdata[15:0];
        `MDSG_A_ACCEL:  inc_next    = wdata[7:0];
        `MDSG_A_TBASE:  tb_next     = wdata[7:0];
        default:        ;
      endcase
    end
    rdata_next = 32'h0;
    if (rd_en)
    begin
      case (addr)
        `MDSG_A_CTRL:   rdata_next = {25'h0, 1'b0, run_reg, mode_reg, dir_reg,
                                      drst_reg, ~en_low_reg};
        `MDSG_A_TARGET: rdata_next = {16'h0, target_reg};
        `MDSG_A_ACCEL:  rdata_next = {24'h0, inc_reg};
        `MDSG_A_TBASE:  rdata_next = {24'h0, tb_reg};
        `MDSG_A_STATUS: rdata_next = {13'h0, step_reg, state_reg == MDSG_CRUISE,
                                      state_reg != MDSG_IDLE, rate_reg};
        default:
        begin
          for (int i = 0; i < 4; i++)
            if (addr == `MDSG_A_PWM0 + 8'(i) * `MDSG_A_PWM_STRIDE)
              rdata_next = {24'h0, duty_reg[i]};
        end
      endcase
    end
  end

  // millisecond base and ramp interval; both restart while idle
  always_comb
  begin
    ms_tick     = ms_cnt_reg == MS_LAST;
    ms_cnt_next = ms_tick ? 17'h0 : ms_cnt_reg + 17'h1;
    // time base 0 behaves like 1: one change per millisecond
    ramp_tick   = ms_tick && ({1'b0, tb_cnt_reg} + 9'h1 >= {1'b0, tb_reg}); // [RULE11]
    tb_cnt_next = tb_cnt_reg;
    if (ramp_tick)
      tb_cnt_next = 8'h0;
    else if (ms_tick)
      tb_cnt_next = tb_cnt_reg + 8'h1;
    if (state_reg == MDSG_IDLE)
    begin
      ms_cnt_next = 17'h0;
      tb_cnt_next = 8'h0;
    end
  end

  // one increment and one time base serve both ramp directions [RULE14]
  always_comb
  begin
    up_sum = {1'b0, rate_reg} + {9'h0, inc_reg};
    if (rate_reg < target_reg)
      toward = (up_sum >= {1'b0, target_reg} || inc_reg == 8'h0)
               ? target_reg : up_sum[15:0];                        // [RULE15]
    else
      toward = (rate_reg - target_reg <= {8'h0, inc_reg} || inc_reg == 8'h0)
               ? target_reg : rate_reg - {8'h0, inc_reg};          // [RULE15]
    down0 = (rate_reg <= {8'h0, inc_reg} || inc_reg == 8'h0)
            ? 16'h0 : rate_reg - {8'h0, inc_reg};                  // [RULE15]
  end

  always_comb
  begin
    state_next = state_reg;
    rate_next  = rate_reg;
    case (state_reg)
      MDSG_IDLE:
      begin
        rate_next = 16'h0;
        if (run_reg)
          state_next = MDSG_RAMP;
      end
      MDSG_RAMP:
      begin
        if (!run_reg)
          state_next = MDSG_DECEL;
        else if (ramp_tick)
        begin
          rate_next = toward;                                      // [RULE10]
          if (toward == target_reg)
            state_next = MDSG_CRUISE;                              // [RULE12]
        end
      end
      MDSG_CRUISE:
      begin
        if (!run_reg)
          state_next = MDSG_DECEL;
        else if (rate_reg != target_reg)
          state_next = MDSG_RAMP;
      end
      MDSG_DECEL:
      begin
        if (run_reg)
          state_next = MDSG_RAMP;
        else if (ramp_tick)
        begin
          rate_next = down0;                                       // [RULE13]
          if (down0 == 16'h0)
            state_next = MDSG_IDLE;
        end
      end
      default:
      begin
        state_next = MDSG_IDLE;
        rate_next  = 16'h0;
      end
    endcase
  end

  // step timing: rate accumulates each cycle, one step per clock-rate overflow.
  // pulse is high then low for a fixed time each; at the top rate the period
  // is far longer, so no accumulator step is ever dropped
  always_comb
  begin
    acc_sum    = {1'b0, acc_reg} + {13'h0, rate_reg};
    acc_next   = acc_reg;
    step_event = 1'b0;
    if (state_reg == MDSG_IDLE)
    begin
      acc_next   = 28'h0;
      step_event = pulse_req;
    end
    else if (acc_sum >= {1'b0, CLK_HZ})
    begin
      acc_next   = 28'(acc_sum - {1'b0, CLK_HZ});
      step_event = 1'b1;
    end
    else
      acc_next = acc_sum[27:0];
    step_cnt_next = step_cnt_reg;
    if (step_cnt_reg != 8'h0)
      step_cnt_next = (step_cnt_reg == 8'(2 * `MDSG_STEP_HI)) ? 8'h0 : step_cnt_reg + 8'h1;
    else if (step_event)
      step_cnt_next = 8'h1;
    step_next = step_cnt_next != 8'h0 && step_cnt_next <= `MDSG_STEP_HI; // [RULE4]
  end

  // pwm: 255 slots per period; a slot is high while the count is below the setting
  always_comb
  begin
    pre_next     = (pre_reg == PWM_PRE) ? 4'h0 : pre_reg + 4'h1;
    pwm_cnt_next = pwm_cnt_reg;
    if (pre_reg == PWM_PRE)                                        // [RULE8]
      pwm_cnt_next = (pwm_cnt_reg == `MDSG_DUTY_MAX - 8'h1) ? 8'h0 : pwm_cnt_reg + 8'h1;
  end

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_pwm
      // count tops at 254, so 255 stays high and 0 stays low
      always_comb
        pwm_next[g] = pwm_cnt_next < duty_next[g];                 // [RULE3] [RULE9]

      pwm_extremes_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE9]
        (duty_reg[g] == 8'h0 && $past(duty_reg[g]) == 8'h0 |-> !bridge_input_x[g]) and
        (duty_reg[g] == `MDSG_DUTY_MAX && $past(duty_reg[g]) == `MDSG_DUTY_MAX
          |-> bridge_input_x[g]))
        else $error("pwm channel not constant at 0 or 255");
    end
  endgenerate

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      en_low_reg   <= 1'b1;
      drst_reg     <= 1'b0;
      dir_reg      <= 1'b0;
      mode_reg     <= 2'h0;
      run_reg      <= 1'b0;
      target_reg   <= 16'h0;
      inc_reg      <= 8'h0;
      tb_reg       <= 8'h0;
      rdata_reg    <= 32'h0;
      state_reg    <= MDSG_IDLE;
      rate_reg     <= 16'h0;
      ms_cnt_reg   <= 17'h0;
      tb_cnt_reg   <= 8'h0;
      acc_reg      <= 28'h0;
      step_cnt_reg <= 8'h0;
      step_reg     <= 1'b0;
      pre_reg      <= 4'h0;
      pwm_cnt_reg  <= 8'h0;
      pwm_reg      <= 4'h0;
      for (int i = 0; i < 4; i++)
        duty_reg[i] <= 8'h0;
    end
    else
    begin
      en_low_reg   <= en_low_next;
      drst_reg     <= drst_next;
      dir_reg      <= dir_next;
      mode_reg     <= mode_next;
      run_reg      <= run_next;
      target_reg   <= target_next;
      inc_reg      <= inc_next;
      tb_reg       <= tb_next;
      rdata_reg    <= rdata_next;
      state_reg    <= state_next;
      rate_reg     <= rate_next;
      ms_cnt_reg   <= ms_cnt_next;
      tb_cnt_reg   <= tb_cnt_next;
      acc_reg      <= acc_next;
      step_cnt_reg <= step_cnt_next;
      step_reg     <= step_next;
      pre_reg      <= pre_next;
      pwm_cnt_reg  <= pwm_cnt_next;
      pwm_reg      <= pwm_next;
      for (int i = 0; i < 4; i++)
        duty_reg[i] <= duty_next[i];
    end
  end

  assign rdata            = rdata_reg;
  assign drive_enable_low = en_low_reg;
  assign drv_reset        = drst_reg;
  assign dir_out          = dir_reg;
  assign step_mode_hi     = mode_reg[1];
  assign step_mode_lo     = mode_reg[0];
  assign step_out         = step_reg;
  assign bridge_input_x   = pwm_reg;

  enable_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE1]
    wr_en && addr == `MDSG_A_CTRL |=> drive_enable_low == !$past(wdata[`MDSG_B_ENABLE]))
    else $error("enable output does not follow control write");

  reset_line_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE2]
    wr_en && addr == `MDSG_A_CTRL |=> drv_reset == $past(wdata[`MDSG_B_DRVRST]))
    else $error("driver reset does not follow control write");

  step_width_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE4]
    $fell(step_out) |-> $past(step_cnt_reg) == `MDSG_STEP_HI)
    else $error("step pulse width wrong");

  dir_write_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE5]
    wr_en && addr == `MDSG_A_CTRL |=> dir_out == $past(wdata[`MDSG_B_DIR]))
    else $error("direction does not follow control write");

  mode_legal_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE6]
    !(step_mode_hi && step_mode_lo))
    else $error("reserved step mode driven");

  pwm_slot_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE8]
    $changed(pwm_cnt_reg) |-> $past(pre_reg) == PWM_PRE)
    else $error("pwm slot advanced off prescale");

  cruise_hold_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE12]
    state_reg == MDSG_CRUISE |-> rate_reg == $past(target_reg))
    else $error("cruise rate differs from target");

  ramp_up_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE15]
    state_reg == MDSG_RAMP && run_reg && ramp_tick && rate_reg < target_reg
      |=> rate_reg > $past(rate_reg) && rate_reg <= $past(target_reg))
    else $error("acceleration step wrong or overshoots");

  ramp_gate_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE11]
    $changed(rate_reg) && $past(state_reg) != MDSG_IDLE |-> $past(ramp_tick))
    else $error("rate changed outside a ramp interval");

  decel_step_a: assert property (@(posedge mclk) disable iff (!rst_n) // [RULE13]
    state_reg == MDSG_DECEL && !run_reg && ramp_tick && inc_reg != 8'h0
      |=> rate_reg == (($past(rate_reg) > {8'h0, $past(inc_reg)})
                       ? $past(rate_reg) - {8'h0, $past(inc_reg)} : 16'h0))
    else $error("deceleration step wrong");

endmodule

// File: verif/mdsg_driver_model.sv
// behavioural model of the driver chip inputs: counts steps, resets and illegal mode codes
`timescale 1ns/10ps
module mdsg_driver_model
(
  input  wire logic mclk,             // system clock
  input  wire logic rst_n,            // synchronous reset, active low
  input  wire logic drive_enable_low, // driver enable, active low
  input  wire logic drv_reset,        // driver reset line
  input  wire logic step_out,         // step pulse
  input  wire logic dir_out,          // rotation sense
  input  wire logic step_mode_hi,     // step mode high bit
  input  wire logic step_mode_lo,     // step mode low bit
  output int        steps_fwd,        // forward steps taken
  output int        steps_rev,        // reverse steps taken
  output int        bad_mode,         // cycles with the reserved mode code
  output int        resets_seen       // completed high-then-low resets
);
  logic step_prev;
  logic rst_prev;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      step_prev   <= 1'b0;
      rst_prev    <= 1'b0;
      steps_fwd   <= 0;
      steps_rev   <= 0;
      bad_mode    <= 0;
      resets_seen <= 0;
    end
    else
    begin
      step_prev <= step_out;
      rst_prev  <= drv_reset;
      // a chip held in reset or disabled ignores step edges
      if (step_out && !step_prev && !drive_enable_low && !drv_reset)
      begin
        if (dir_out)
          steps_fwd <= steps_fwd + 1;
        else
          steps_rev <= steps_rev + 1;
      end
      if (rst_prev && !drv_reset)
        resets_seen <= resets_seen + 1;
      if (step_mode_hi && step_mode_lo)
        bad_mode <= bad_mode + 1;
    end
  end
endmodule

// File: verif/motor_driver_signal_gen_test.sv
// self-checking testbench of the motor signal generator
`timescale 1ns/10ps
`include "mdsg_regs.svh"
module motor_driver_signal_gen_test;
  import mdsg_pkg::*;
  localparam int          MS_CYC  = 20;
  localparam int          PWM_PER = `MDSG_PWM_STEPS * `MDSG_PWM_PRE;
  localparam logic [31:0] EN      = 32'h1 << `MDSG_B_ENABLE;
  localparam logic [31:0] RUN     = 32'h1 << `MDSG_B_RUN;
  logic        mclk;
  logic        rst_n;
  logic [7:0]  addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic        wr_en;
  logic        rd_en;
  logic        drive_enable_low;
  logic        drv_reset;
  logic [3:0]  bridge_input_x;
  logic        step_out;
  logic        dir_out;
  logic        step_mode_hi;
  logic        step_mode_lo;
  int          n_fail;
  int          checks;
  int          steps_fwd;
  int          steps_rev;
  int          bad_mode;
  int          resets_seen;
  int          hi_run = 0;
  int          last_width = 0;

  mdsg_top #(.MS_CYCLES(MS_CYC)) dut_u (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .drive_enable_low(drive_enable_low), .drv_reset(drv_reset),
    .bridge_input_x(bridge_input_x), .step_out(step_out), .dir_out(dir_out),
    .step_mode_hi(step_mode_hi), .step_mode_lo(step_mode_lo));

  mdsg_driver_model drv_u (.mclk(mclk), .rst_n(rst_n), .drive_enable_low(drive_enable_low),
    .drv_reset(drv_reset), .step_out(step_out), .dir_out(dir_out),
    .step_mode_hi(step_mode_hi), .step_mode_lo(step_mode_lo), .steps_fwd(steps_fwd),
    .steps_rev(steps_rev), .bad_mode(bad_mode), .resets_seen(resets_seen));

  always #5 mclk = ~mclk;

  // width in cycles of the latest step pulse; the write task hides its first cycles
  always @(posedge mclk)
  begin
    if (step_out === 1'b1)
      hi_run <= hi_run + 1;
    else
    begin
      if (hi_run != 0)
        last_width <= hi_run;
      hi_run <= 0;
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic write_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
    @(posedge mclk);
    #1;
  endtask

  task automatic read_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge mclk);
    rd_en <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic t_ctrl;
    logic [31:0] d;
    check("enable off", drive_enable_low, 1);
    write_reg(`MDSG_A_CTRL, EN);
    check("enable on", drive_enable_low, 0);
    read_reg(`MDSG_A_CTRL, d);
    check("ctrl enable", d[`MDSG_B_ENABLE], 1);
    write_reg(`MDSG_A_CTRL, EN | (32'h1 << `MDSG_B_DRVRST));
    check("reset high", drv_reset, 1);
    write_reg(`MDSG_A_CTRL, EN);
    check("reset low", drv_reset, 0);
    check("reset count", resets_seen, 1);
    write_reg(`MDSG_A_CTRL, EN | (32'h1 << `MDSG_B_DIR));
    check("dir fwd", dir_out, 1);
    for (int m = 0; m < 4; m++)
    begin
      write_reg(`MDSG_A_CTRL, EN | (32'(m) << `MDSG_B_MODE_LO));
      // the reserved code must leave wave drive in place
      check("mode", {step_mode_hi, step_mode_lo}, (m == 3) ? 2'h2 : 2'(m));
    end
    check("reserved mode", bad_mode, 0);
    check("dir rev", dir_out, 0);
    write_reg(8'h40, 32'hffffffff);
    read_reg(8'h40, d);
    check("unmapped", d, 0);
  endtask

  task automatic t_pwm;
    logic [7:0] duty [4];
    int         hi   [4];
    duty = '{8'h00, 8'hff, 8'h80, 8'h01};
    for (int i = 0; i < 4; i++)
      write_reg(8'(`MDSG_A_PWM0 + i * `MDSG_A_PWM_STRIDE), {24'h0, duty[i]});
    hi = '{0, 0, 0, 0};
    // any window of exactly one period holds duty*prescale high cycles
    repeat (PWM_PER)
    begin
      @(posedge mclk);
      #1;
      for (int i = 0; i < 4; i++)
        hi[i] += bridge_input_x[i];
    end
    for (int i = 0; i < 4; i++)
      check("pwm high", hi[i], duty[i] * `MDSG_PWM_PRE);
  endtask

  task automatic t_pulse(input logic fwd);
    int n;
    int w;
    n = 0;
    w = 0;
    last_width = 0;
    write_reg(`MDSG_A_CTRL, EN | (32'(fwd) << `MDSG_B_DIR) | (32'h1 << `MDSG_B_PULSE));
    while (step_out !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (step_out === 1'b1 && w < 300)
    begin
      @(posedge mclk);
      #1;
      w++;
    end
    @(posedge mclk);
    #1;
    check("step width", last_width, `MDSG_STEP_HI);
    repeat (2 * `MDSG_STEP_HI) @(posedge mclk);
    #1;
    check("steps", fwd ? steps_fwd : steps_rev, 1);
  endtask

  task automatic wait_rate(input logic [15:0] exp, inout logic [15:0] cur, inout time last,
                           input bit timed);
    logic [31:0] d;
    int          n;
    n = 0;
    d = {16'h0, cur};
    while (d[15:0] === cur && n < 300)
    begin
      read_reg(`MDSG_A_STATUS, d);
      n++;
    end
    check("rate", d[15:0], exp);
    if (timed)
      check("ramp interval", 32'($time - last), 2 * MS_CYC * 10);
    cur = d[15:0];
    last = $time;
  endtask

  task automatic t_ramp;
    logic [15:0] cur;
    time         last;
    logic [31:0] d;
    logic [15:0] up_seq [4];
    logic [15:0] down_seq [4];
    cur = 16'h0;
    last = 0;
    up_seq = '{16'h3, 16'h6, 16'h9, 16'ha};
    down_seq = '{16'h7, 16'h4, 16'h1, 16'h0};
    write_reg(`MDSG_A_ACCEL, 32'h3);
    write_reg(`MDSG_A_TBASE, 32'h2);
    write_reg(`MDSG_A_TARGET, 32'ha);
    write_reg(`MDSG_A_CTRL, EN | RUN);
    foreach (up_seq[i])
      wait_rate(up_seq[i], cur, last, i > 0);
    repeat (100) read_reg(`MDSG_A_STATUS, d);
    check("cruise rate", d[15:0], 16'ha);
    check("cruise flag", d[`MDSG_S_CRUISE], 1);
    write_reg(`MDSG_A_CTRL, EN);
    foreach (down_seq[i])
      wait_rate(down_seq[i], cur, last, i > 0);
    repeat (4) read_reg(`MDSG_A_STATUS, d);
    check("halted", d[`MDSG_S_RUNNING], 0);
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial
  begin
    #400000;
    n_fail++;
    $display("FAIL watchdog expected done seen hang");
    report_and_stop();
  end

  initial
  begin
    mclk = 1'b0;
    rst_n = 1'b0;
    addr = 8'h0;
    wdata = 32'h0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    n_fail = 0;
    checks = 0;
    repeat (6) @(posedge mclk);
    #1;
    check("reset outputs", {drv_reset, bridge_input_x, step_out, dir_out, step_mode_hi,
                            step_mode_lo}, 0);
    @(posedge mclk);
    rst_n <= 1'b1;
    t_ctrl();
    t_pwm();
    t_pulse(1'b1);
    t_pulse(1'b0);
    t_ramp();
    report_and_stop();
  end
endmodule
